// ==== core/uart_receive_path.sv ====
`timescale 1ns/10ps

// Summary of operation
// - shift data in lsb first into buffer
// - enable starts hunting for start bit
// - frame end loads buffer, sets data ready
// - read, dma read or flush clears ready
// - break frame counts as framing error
// - idle frame handled like a character
// - overrun keeps buffer, sets overrun flag
// - unserviced dma request also causes overrun
// - overrun interrupts with ready or error enable
// - overrun clears only by overrun clear
// - select sixteen or eight times oversampling
// - majority vote or single center sample
// - vote table gives bit and noise
// - noise flag rises with data ready
// - dma mode noise and framing errors interrupt with error enable
// - noise clear bit clears noise flag
// - lin, smartcard, irda force sixteen oversampling
// - missing stop sets framing error, loads data
// - framing clear bit clears framing flag
// - half stop bit is sampled once at its end but never checked
// - one stop sampled on 8,9,10, or 4,5,6 in eight times mode
// - one and half stop sampled 16-18
// - two stops: check first, ready after it
// - word length codes 10,00,01
// - start confirmed by center samples, plus 3,5,7 in sixteen times mode
module uart_receive_path (
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_rx_line,
    input  wire logic       i_os_tick,
    input  wire logic       i_peripheral_enable,
    input  wire logic       i_rx_path_enable,
    input  wire logic [1:0] i_word_length,
    input  wire logic [1:0] i_stop_bits,
    input  wire logic       i_parity_enable,
    input  wire logic       i_parity_odd,
    input  wire logic       i_half_oversample_select,
    input  wire logic       i_single_sample_select,
    input  wire logic       i_special_mode,
    input  wire logic       i_rx_dma_enable,
    input  wire logic       i_rx_ready_irq_enable,
    input  wire logic       i_error_irq_enable,
    input  wire logic       i_idle_irq_enable,
    input  wire logic       i_rx_buffer_read,
    input  wire logic       i_rx_dma_ack,
    input  wire logic       i_rx_flush_request,
    input  wire logic       i_overrun_clear,
    input  wire logic       i_noise_clear,
    input  wire logic       i_framing_clear,
    input  wire logic       i_parity_clear,
    input  wire logic       i_idle_clear,
    output logic [8:0]      o_rx_buffer_word,
    output logic            o_rx_data_ready_flag,
    output logic            o_overrun_flag,
    output logic            o_noise_flag,
    output logic            o_framing_error_flag,
    output logic            o_parity_error_flag,
    output logic            o_idle_flag,
    output logic            o_rx_dma_request,
    output logic            o_irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_STOP  = 4'b1000
    } rx_phase_t;

    typedef struct packed
    {
        rx_phase_t  phase;
        logic       line_prev;
        logic [4:0] sample_cnt;
        logic [3:0] bit_cnt;
        logic [2:0] early;
        logic [2:0] center;
        logic [9:0] shift;
        logic       frame_noise;
        logic       all_ones;
        logic       all_zeros;
        logic       frame_error;
        logic [8:0] buffer;
        logic       ready;
        logic       overrun;
        logic       noise;
        logic       framing;
        logic       parity;
        logic       idle;
        logic       dma_pending;
    } rx_state_t;

    rx_state_t s;
    rx_state_t next_s;

    logic       line;
    logic       vote_bit;
    logic       vote_noise;
    logic       ovs8;
    logic [4:0] bit_len;
    logic [4:0] mid_a;
    logic [4:0] mid_c;
    logic [3:0] frame_bits;
    logic       par_calc;
    logic       running;
    logic       done;
    logic [8:0] word;

    rx_sync2 #(
        .RESET_LEVEL (1'b1)
    ) u_line_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (i_rx_line),
        .o_sync     (line)
    );

    rx_vote3 u_vote (
        .i_samples (s.center),
        .i_single  (i_single_sample_select),
        .o_bit     (vote_bit),
        .o_noise   (vote_noise)
    );

    // ****************************************************************
    // configuration decode
    // ****************************************************************
    always_comb
    begin
        ovs8    = i_half_oversample_select & ~i_special_mode;
        bit_len = ovs8 ? rx_path_pkg::OS8_SAMPLES : rx_path_pkg::OS16_SAMPLES;
        mid_a   = ovs8 ? rx_path_pkg::OS8_MID_A : rx_path_pkg::OS16_MID_A;
        mid_c   = ovs8 ? rx_path_pkg::OS8_MID_C : rx_path_pkg::OS16_MID_C;
        case (i_word_length)
            rx_path_pkg::WORD_LEN_7: frame_bits = 4'h7;
            rx_path_pkg::WORD_LEN_9: frame_bits = 4'h9;
            default:                 frame_bits = 4'h8;
        endcase
        running = i_peripheral_enable & i_rx_path_enable;
    end

    // ****************************************************************
    // receive sequencer and flags
    // ****************************************************************
    always_comb
    begin
        next_s    = s;
        done      = 1'b0;
        word      = rx_path_pkg::RESET_DATA;
        par_calc  = 1'b0;

        if (i_os_tick)
        begin
            // edge detect compares successive samples; a per-clock compare misses edges
            next_s.line_prev = line;
            case (s.phase)
                ST_IDLE:
                begin
                    // falling edge opens start hunt
                    if (running && s.line_prev && !line)
                    begin
                        next_s.phase      = ST_START;
                        next_s.sample_cnt = 5'h2;
                    end
                end
                ST_START:
                begin
                    next_s.sample_cnt = s.sample_cnt + 5'h1;
                    if (s.sample_cnt == rx_path_pkg::START_EARLY_A)
                        next_s.early[0] = line;
                    if (s.sample_cnt == rx_path_pkg::START_EARLY_A + 5'h2)
                        next_s.early[1] = line;
                    if (s.sample_cnt == rx_path_pkg::START_EARLY_C)
                        next_s.early[2] = line;
                    if (s.sample_cnt >= mid_a && s.sample_cnt <= mid_c)
                        next_s.center = {line, s.center[2:1]};
                    if (s.sample_cnt == bit_len)
                    begin
                        // two highs in center samples, or in early samples at 16x, reject silently
                        if ((!ovs8 && ((s.early[0] & s.early[1]) | (s.early[0] & s.early[2]) |
                                       (s.early[1] & s.early[2]))) ||
                            ((s.center[0] & s.center[1]) | (s.center[0] & s.center[2]) |
                             (s.center[1] & s.center[2])))
                            next_s.phase = ST_IDLE;
                        else
                        begin
                            next_s.phase       = ST_DATA;
                            next_s.frame_noise = (s.center != 3'h0) && !i_single_sample_select;
                            next_s.bit_cnt     = 4'h0;
                            next_s.all_ones    = 1'b0;
                            next_s.all_zeros   = 1'b1;
                        end
                        next_s.sample_cnt = 5'h1;
                    end
                end
                ST_DATA:
                begin
                    next_s.sample_cnt = s.sample_cnt + 5'h1;
                    if (s.sample_cnt >= mid_a && s.sample_cnt <= mid_c)
                        next_s.center = {line, s.center[2:1]};
                    if (s.sample_cnt == bit_len)
                    begin
                        next_s.sample_cnt = 5'h1;
                        next_s.shift = {vote_bit, s.shift[9:1]};
                        next_s.frame_noise = s.frame_noise | vote_noise;
                        next_s.all_zeros = s.all_zeros & ~vote_bit;
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                        if (s.bit_cnt + 4'h1 == frame_bits)
                            next_s.phase = ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    next_s.sample_cnt = s.sample_cnt + 5'h1;
                    if (i_stop_bits == rx_path_pkg::STOP_ONE_HALF)
                    begin
                        if (s.sample_cnt >= rx_path_pkg::STOP15_MID_A &&
                            s.sample_cnt <= rx_path_pkg::STOP15_MID_C)
                            next_s.center = {line, s.center[2:1]};
                    end
                    else if (s.sample_cnt >= mid_a && s.sample_cnt <= mid_c)
                        next_s.center = {line, s.center[2:1]};
                    if ((i_stop_bits == rx_path_pkg::STOP_HALF &&
                         s.sample_cnt == {1'b0, bit_len[4:1]}) ||
                        (i_stop_bits == rx_path_pkg::STOP_ONE_HALF &&
                         s.sample_cnt == rx_path_pkg::STOP15_SAMPLES) ||
                        (i_stop_bits[1] == 1'b0 && i_stop_bits[0] == 1'b0 &&
                         s.sample_cnt == bit_len) ||
                        (i_stop_bits == rx_path_pkg::STOP_TWO &&
                         s.sample_cnt == bit_len))
                    begin
                        done          = 1'b1;
                        next_s.phase  = ST_IDLE;
                    end
                end
                default:
                    next_s.phase = ST_IDLE;
            endcase
        end

        // character word, right aligned by length
        case (i_word_length)
            rx_path_pkg::WORD_LEN_7: word = {2'h0, s.shift[9:3]};
            rx_path_pkg::WORD_LEN_9: word = s.shift[9:1];
            default:                 word = {1'b0, s.shift[9:2]};
        endcase
        // parity bit is the top bit of the word, so every word bit counts
        par_calc = ^word ^ i_parity_odd;

        // ready and dma clear first so a completing frame can set again
        if (i_rx_buffer_read || i_rx_dma_ack || i_rx_flush_request)
            next_s.ready = 1'b0;
        if (i_rx_dma_ack)
            next_s.dma_pending = 1'b0;
        if (i_overrun_clear)
            next_s.overrun = 1'b0;
        if (i_noise_clear)
            next_s.noise = 1'b0;
        if (i_framing_clear)
            next_s.framing = 1'b0;
        if (i_parity_clear)
            next_s.parity = 1'b0;
        if (i_idle_clear)
            next_s.idle = 1'b0;

        if (done)
        begin
            if (s.ready || s.dma_pending)
                next_s.overrun = 1'b1;
            else
            begin
                next_s.buffer  = word;
                next_s.ready   = 1'b1;
                next_s.dma_pending = i_rx_dma_enable;
                if (s.frame_noise)
                    next_s.noise = 1'b1;
                // half stop bit skips the check; break has a low stop
                if (i_stop_bits != rx_path_pkg::STOP_HALF && !vote_bit)
                    next_s.framing = 1'b1;
                if (i_parity_enable && par_calc)
                    next_s.parity = 1'b1;
                if (s.all_ones == 1'b0 && word == ((9'h1 << frame_bits) - 9'h1) &&
                    vote_bit)
                    next_s.idle = 1'b1;
            end
        end

        if (!running)
            next_s.phase = ST_IDLE;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s            <= '0;
            s.phase      <= ST_IDLE;
            s.line_prev  <= 1'b1;
            s.all_zeros  <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_rx_buffer_word     = s.buffer;
    assign o_rx_data_ready_flag = s.ready;
    assign o_overrun_flag       = s.overrun;
    assign o_noise_flag         = s.noise;
    assign o_framing_error_flag = s.framing;
    assign o_parity_error_flag  = s.parity;
    assign o_idle_flag          = s.idle;
    assign o_rx_dma_request     = s.dma_pending;
    assign o_irq = (i_rx_ready_irq_enable & s.ready)
                 | (i_idle_irq_enable & s.idle)
                 | ((i_rx_ready_irq_enable | i_error_irq_enable) & s.overrun)
                 | (i_error_irq_enable & i_rx_dma_enable & (s.noise | s.framing));

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence frame_done_busy;
        done && (s.ready || s.dma_pending);
    endsequence

    chk_overrun_keeps_buffer: assert property (frame_done_busy |=> o_overrun_flag && $stable(o_rx_buffer_word)) else $error("overrun lost buffer");
    chk_ready_on_done: assert property (done && !s.ready && !s.dma_pending |=> o_rx_data_ready_flag) else $error("ready not set");
    chk_read_clears: assert property (i_rx_buffer_read && !done |=> !o_rx_data_ready_flag) else $error("ready not cleared");
    chk_overrun_sticky: assert property (o_overrun_flag && !i_overrun_clear |=> o_overrun_flag) else $error("overrun dropped");
    chk_noise_clear: assert property (i_noise_clear && !done |=> !o_noise_flag) else $error("noise not cleared");
    chk_framing_clear: assert property (i_framing_clear && !done |=> !o_framing_error_flag) else $error("framing not cleared");
    chk_overrun_irq: assert property (o_overrun_flag && i_error_irq_enable |-> o_irq) else $error("overrun irq missing");
    chk_disabled_idle: assert property (!running |=> s.phase == ST_IDLE) else $error("not idle when off");

endmodule : uart_receive_path

// ==== core/rx_path_pkg.sv ====
package rx_path_pkg;

    // ****************************************************************
    // word length codes
    // ****************************************************************
    localparam logic [1:0] WORD_LEN_8 = 2'h0;
    localparam logic [1:0] WORD_LEN_9 = 2'h1;
    localparam logic [1:0] WORD_LEN_7 = 2'h2;

    // ****************************************************************
    // stop bit codes
    // ****************************************************************
    localparam logic [1:0] STOP_ONE      = 2'h0;
    localparam logic [1:0] STOP_HALF     = 2'h1;
    localparam logic [1:0] STOP_TWO      = 2'h2;
    localparam logic [1:0] STOP_ONE_HALF = 2'h3;

    // ****************************************************************
    // sample positions within a bit, counted from 1
    // ****************************************************************
    localparam logic [4:0] OS16_SAMPLES     = 5'h10;
    localparam logic [4:0] OS8_SAMPLES      = 5'h08;
    localparam logic [4:0] OS16_MID_A       = 5'h08;
    localparam logic [4:0] OS16_MID_C       = 5'h0a;
    localparam logic [4:0] OS8_MID_A        = 5'h04;
    localparam logic [4:0] OS8_MID_C        = 5'h06;
    localparam logic [4:0] START_EARLY_A    = 5'h03;
    localparam logic [4:0] START_EARLY_C    = 5'h07;
    localparam logic [4:0] STOP15_MID_A     = 5'h10;
    localparam logic [4:0] STOP15_MID_C     = 5'h12;
    localparam logic [4:0] STOP15_SAMPLES   = 5'h18;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [8:0] RESET_DATA = 9'h000;

endpackage : rx_path_pkg

// ==== core/rx_sync2.sv ====
`timescale 1ns/10ps

// two flip-flop synchroniser; first stage is read only by the second
module rx_sync2 #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic i_core_clk,
    input  wire logic i_rstn,
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed
    {
        logic stage1;
        logic stage2;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb
    begin
        next_state.stage1 = i_async;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            state <= '{stage1: RESET_LEVEL, stage2: RESET_LEVEL};
        else
            state <= next_state;
    end

    assign o_sync = state.stage2;
endmodule : rx_sync2

// ==== core/rx_vote3.sv ====
`timescale 1ns/10ps

// three-sample majority decode with disagreement status
module rx_vote3 (
    input  wire logic [2:0] i_samples,
    input  wire logic       i_single,
    output logic            o_bit,
    output logic            o_noise
);
    always_comb
    begin
        if (i_single)
        begin
            o_bit   = i_samples[1];
            o_noise = 1'b0;
        end
        else
        begin
            o_bit   = (i_samples[2] & i_samples[1]) | (i_samples[2] & i_samples[0])
                    | (i_samples[1] & i_samples[0]);
            o_noise = (i_samples != 3'h0) && (i_samples != 3'h7);
        end
    end
endmodule : rx_vote3

// ==== bench/rx_remote_tx.sv ====
`timescale 1ns/10ps

// ****************************************************************
// remote transmitter, timed in oversampling ticks
// ****************************************************************
module rx_remote_tx (
    input  wire logic i_core_clk,
    input  wire logic i_os_tick,
    output logic      o_line
);
    initial o_line = 1'b1;

    task automatic wait_ticks(input int n);
        repeat (n) @(posedge i_core_clk iff i_os_tick);
    endtask : wait_ticks

    // the glitch hits one sample beside the centre, so a vote still recovers the bit
    task automatic send(input logic [8:0] d, input int nb, input int os, input int st,
                        input int gl, input int lo, input int hi);
        logic lvl;
        wait_ticks(1);
        for (int b = 0; b <= nb; b++)
        begin
            lvl = (b == 0) ? 1'b0 : d[b-1];
            for (int t = 1; t <= os; t++)
            begin
                o_line <= (b == gl && b != 0 && t == os / 2 + 2) ? ~lvl : lvl;
                wait_ticks(1);
            end
        end
        // stop phase is high except for a chosen low stretch
        for (int t = 1; t <= st; t++)
        begin
            o_line <= !(t >= lo && t <= hi);
            wait_ticks(1);
        end
        o_line <= 1'b1;
    endtask : send
endmodule : rx_remote_tx

// ==== bench/uart_receive_path_tb.sv ====
`timescale 1ns/10ps

module uart_receive_path_tb;
    logic       i_core_clk;
    logic       i_rstn;
    logic       os_tick;
    logic       rx_line;
    logic [1:0] tick_cnt;
    logic       pe_en, re_en, par_en, half, single, special, dma, rie, error_irq_enable, iie, podd;
    logic [1:0] wl, sb;
    logic [7:0] pl;
    logic [8:0] word;
    logic       ready, ovr, noise, fe, perr, idle, dreq, irq;
    logic [7:0] f;
    int         fail_count;
    int         num_checks;

    assign f = {ready, ovr, noise, fe, perr, idle, dreq, irq};

    // ****************************************************************
    // clock and oversampling tick, one tick every four clocks
    // ****************************************************************
    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            tick_cnt <= 2'h0;
            os_tick  <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 2'h1;
            os_tick  <= (tick_cnt == 2'h3);
        end
    end

    rx_remote_tx u_tx (.i_core_clk(i_core_clk), .i_os_tick(os_tick), .o_line(rx_line));

    uart_receive_path DUT (
        .i_core_clk               (i_core_clk),
        .i_rstn                   (i_rstn),
        .i_rx_line                (rx_line),
        .i_os_tick                (os_tick),
        .i_peripheral_enable      (pe_en),
        .i_rx_path_enable         (re_en),
        .i_word_length            (wl),
        .i_stop_bits              (sb),
        .i_parity_enable          (par_en),
        .i_parity_odd             (podd),
        .i_half_oversample_select (half),
        .i_single_sample_select   (single),
        .i_special_mode           (special),
        .i_rx_dma_enable          (dma),
        .i_rx_ready_irq_enable    (rie),
        .i_error_irq_enable       (error_irq_enable),
        .i_idle_irq_enable        (iie),
        .i_rx_buffer_read         (pl[0]),
        .i_rx_dma_ack             (pl[1]),
        .i_rx_flush_request       (pl[2]),
        .i_overrun_clear          (pl[3]),
        .i_noise_clear            (pl[4]),
        .i_framing_clear          (pl[5]),
        .i_parity_clear           (pl[6]),
        .i_idle_clear             (pl[7]),
        .o_rx_buffer_word         (word),
        .o_rx_data_ready_flag     (ready),
        .o_overrun_flag           (ovr),
        .o_noise_flag             (noise),
        .o_framing_error_flag     (fe),
        .o_parity_error_flag      (perr),
        .o_idle_flag              (idle),
        .o_rx_dma_request         (dreq),
        .o_irq                    (irq)
    );

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // order: ready overrun noise framing parity idle dma_request irq
    task automatic flags(input logic [7:0] e);
        chk("flags", {1'b0, e}, {1'b0, f});
    endtask : flags

    task automatic pulse(input logic [7:0] m);
        @(posedge i_core_clk);
        pl <= m;
        @(posedge i_core_clk);
        pl <= 8'h00;
        @(posedge i_core_clk);
    endtask : pulse

    task automatic frame(input logic [8:0] d, input int nb, input int os, input int st,
                         input int gl, input int lo, input int hi);
        u_tx.send(d, nb, os, st, gl, lo, hi);
        repeat (2) @(posedge i_core_clk);
    endtask : frame

    task automatic results;
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // ****************************************************************
    // watchdog: about 25 frames of 640 clocks each, with wide margin
    // ****************************************************************
    initial
    begin
        repeat (60000) @(posedge i_core_clk);
        fail_count++;
        results();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        {i_rstn, pl, fail_count, num_checks} = '0;
        {pe_en, re_en, par_en, half, single, special, dma, rie, error_irq_enable, iie, podd} = '0;
        wl = rx_path_pkg::WORD_LEN_8;
        sb = rx_path_pkg::STOP_ONE;
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        chk("word", rx_path_pkg::RESET_DATA, word);
        flags(8'h00);
        pe_en <= 1'b1;
        frame(9'h0a5, 8, 16, 16, 0, 0, 0);
        flags(8'h00);
        re_en <= 1'b1;
        rie   <= 1'b1;
        u_tx.send(9'h000, 0, 2, 0, 0, 0, 0);
        u_tx.wait_ticks(16);
        flags(8'h00);
        frame(9'h0a5, 8, 16, 16, 0, 0, 0);
        chk("word", 9'h0a5, word);
        flags(8'h81);
        pulse(8'h01);
        flags(8'h00);
        frame(9'h03c, 8, 16, 16, 0, 0, 0);
        frame(9'h0c3, 8, 16, 16, 0, 0, 0);
        chk("word", 9'h03c, word);
        flags(8'hc1);
        pulse(8'h04);
        flags(8'h41);
        rie <= 1'b0;
        error_irq_enable <= 1'b1;
        @(posedge i_core_clk);
        @(posedge i_core_clk);
        flags(8'h41);
        pulse(8'h08);
        flags(8'h00);
        frame(9'h05a, 8, 16, 16, 3, 0, 0);
        chk("word", 9'h05a, word);
        flags(8'ha0);
        pulse(8'h11);
        flags(8'h00);
        single <= 1'b1;
        frame(9'h05a, 8, 16, 16, 3, 0, 0);
        flags(8'h80);
        pulse(8'h01);
        single <= 1'b0;
        frame(9'h0ff, 8, 16, 16, 0, 1, 16);
        chk("word", 9'h0ff, word);
        flags(8'h90);
        pulse(8'h21);
        flags(8'h00);
        frame(9'h000, 8, 16, 16, 0, 1, 16);
        flags(8'h90);
        pulse(8'h21);
        sb <= rx_path_pkg::STOP_HALF;
        frame(9'h012, 8, 16, 8, 0, 1, 8);
        flags(8'h80);
        pulse(8'h01);
        sb <= rx_path_pkg::STOP_ONE_HALF;
        frame(9'h012, 8, 16, 16, 0, 1, 8);
        flags(8'h00);
        u_tx.wait_ticks(8);
        repeat (2) @(posedge i_core_clk);
        flags(8'h80);
        pulse(8'h01);
        frame(9'h012, 8, 16, 24, 0, 16, 18);
        flags(8'h90);
        pulse(8'h21);
        sb <= rx_path_pkg::STOP_TWO;
        frame(9'h034, 8, 16, 16, 0, 0, 0);
        flags(8'h80);
        pulse(8'h01);
        sb <= rx_path_pkg::STOP_ONE;
        for (int i = 0; i < 2; i++)
        begin
            wl <= (i == 0) ? rx_path_pkg::WORD_LEN_7 : rx_path_pkg::WORD_LEN_9;
            frame(9'h1a5, (i == 0) ? 7 : 9, 16, 16, 0, 0, 0);
            chk("word", (i == 0) ? 9'h025 : 9'h1a5, word);
            pulse(8'h01);
        end
        wl   <= rx_path_pkg::WORD_LEN_8;
        half <= 1'b1;
        frame(9'h0c9, 8, 8, 8, 0, 0, 0);
        chk("word", 9'h0c9, word);
        pulse(8'h01);
        special <= 1'b1;
        frame(9'h06e, 8, 16, 16, 0, 0, 0);
        chk("word", 9'h06e, word);
        pulse(8'h01);
        {half, special} <= 2'h0;
        par_en <= 1'b1;
        frame(9'h001, 8, 16, 16, 0, 0, 0);
        flags(8'h88);
        pulse(8'h41);
        podd <= 1'b1;
        frame(9'h081, 8, 16, 16, 0, 0, 0);
        flags(8'h88);
        pulse(8'h41);
        podd <= 1'b0;
        frame(9'h081, 8, 16, 16, 0, 0, 0);
        flags(8'h80);
        pulse(8'h01);
        par_en <= 1'b0;
        iie    <= 1'b1;
        frame(9'h0ff, 8, 16, 16, 0, 0, 0);
        flags(8'h85);
        pulse(8'h81);
        flags(8'h00);
        iie    <= 1'b0;
        dma    <= 1'b1;
        frame(9'h011, 8, 16, 16, 0, 0, 0);
        flags(8'h82);
        pulse(8'h01);
        flags(8'h02);
        frame(9'h022, 8, 16, 16, 0, 0, 0);
        chk("word", 9'h011, word);
        flags(8'h43);
        pulse(8'h0a);
        flags(8'h00);
        frame(9'h05a, 8, 16, 16, 3, 0, 0);
        flags(8'ha3);
        pulse(8'h12);
        flags(8'h00);
        results();
    end
endmodule : uart_receive_path_tb
